//--- bench/fbs_sec_model.sv
// secondary-side request model facing the primary sequencer
`timescale 1ns/1ps
module fbs_sec_model #(
  parameter int MIN_OFF = 500,
  parameter logic [7:0] DEMAG = 8'h40
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic switch_on,
  input wire logic go,
  output logic cycle_request,
  output logic rehandshake,
  output logic sync_rectifier_switch
);
  logic [15:0] off_q;
  logic [3:0] miss_q;
  logic sw_q;
  logic seen_q;
  logic [2:0] extra_q;
  logic [7:0] dem_q;
  logic req_d;
  assign req_d = go && !switch_on && off_q >= 16'(MIN_OFF);
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      off_q <= 16'hffff;
    else
      off_q <= switch_on ? 16'h0000 : off_q + {15'h0000, ~&off_q};
  // min off since conduction also caps the request rate
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      cycle_request <= 1'b0;
    else
      cycle_request <= req_d;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      sw_q <= 1'b0;
    else
      sw_q <= switch_on;
  // conductions that no request preceded
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      seen_q <= 1'b0;
      extra_q <= 3'h0;
    end
    else if (switch_on && !sw_q)
    begin
      seen_q <= 1'b0;
      extra_q <= seen_q ? 3'h0 : extra_q + {2'h0, !extra_q[2]};
    end
    else if (cycle_request)
      seen_q <= 1'b1;
  // forward sense falls as the primary turns off; a demag count stands for the zero crossing
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      sync_rectifier_switch <= 1'b0;
      dem_q <= 8'h00;
    end
    else if (sw_q && !switch_on)
    begin
      sync_rectifier_switch <= 1'b1;
      dem_q <= DEMAG;
    end
    else if (req_d)
      sync_rectifier_switch <= 1'b0;
    else if (dem_q == 8'h00)
      sync_rectifier_switch <= 1'b0;
    else
      dem_q <= dem_q - 8'h01;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      miss_q <= 4'h0;
    else
      miss_q <= switch_on ? 4'h0 : miss_q + {3'h0, cycle_request && !miss_q[3]};
  assign rehandshake = miss_q[3] || extra_q[2];
endmodule // fbs_sec_model

//--- bench/fbs_seq_props.sv
// port assertions for the flyback sequencer
`timescale 1ns/1ps
module fbs_seq_props
  import fbs_pkg::*;
#(
  parameter int BROWNOUT_DELAY = 4000,
  parameter int RESTART_OFF_INTERVAL = 3000
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire fbs_pkg::fbs_sense_s sense,
  input wire logic cycle_request,
  input wire logic switch_on,
  input wire logic line_sense_connect,
  input wire fbs_pkg::fbs_status_s status
);
  logic [2:0] g;
  logic [15:0] run_q [3];
  logic [15:0] off_q;
  logic [15:0] bo_q;
  logic ctl;
  assign g = {status.restart_off, status.rectifier_short_guard, status.safe_area_guard};
  assign ctl = status.secondary_ctrl || status.self_ctrl;
  function automatic logic [15:0] inc(logic [15:0] v);
    return v + {15'h0000, ~&v};
  endfunction
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      off_q <= 16'h0000;
      bo_q <= 16'h0000;
      run_q <= '{default: 16'h0000};
    end
    else
    begin
      off_q <= switch_on ? 16'h0000 : inc(off_q);
      bo_q <= sense.line_brown_out ? inc(bo_q) : 16'h0000;
      for (int i = 0; i < 3; i++)
        run_q[i] <= g[i] ? inc(run_q[i]) : 16'h0000;
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_skip_len: assert property ($fell(g[0]) |-> run_q[0] inside {[3117:3133]})
    else $error("skip length wrong");
  a_short_len: assert property ($fell(g[1]) |-> run_q[1] inside {[3742:3758]})
    else $error("short off length wrong");
  a_restart_len: assert property ($fell(g[2]) |-> run_q[2] >= RESTART_OFF_INTERVAL)
    else $error("restart off too short");
  a_sense_cut: assert property ($fell(line_sense_connect) |-> off_q >= 6242)
    else $error("sense cut early");
  a_sense_back: assert property ($rose(switch_on) |-> ##[0:2] line_sense_connect)
    else $error("sense not back");
  a_slave_req: assert property ($rose(switch_on) && status.secondary_ctrl
    |-> $past(cycle_request, 2) || $past(cycle_request, 3))
    else $error("slave switched unasked");
  a_listen_idle: assert property ((!ctl)[*3] |-> !switch_on)
    else $error("switched while idle");
  a_over_stop: assert property (sense.line_over && ctl |-> ##[1:4] status.restart_off)
    else $error("over not stopped");
  a_brown_stop: assert property (bo_q > BROWNOUT_DELAY + 4 |-> !ctl)
    else $error("brown not stopped");
  a_audio_mute: assert property (cycle_request && off_q inside {[10383:24992]}
    |-> ##1 (!switch_on)[*4])
    else $error("audio band switched");
  cover property ($rose(status.secondary_ctrl));
  cover property ($rose(status.restart_off));
  cover property ($fell(line_sense_connect));
endmodule // fbs_seq_props

//--- bench/fbs_seq_test.sv
// self-checking bench for the flyback sequencer
`timescale 1ns/1ps
module fbs_seq_test;
  import fbs_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic cycle_request, switch_on, line_sense_connect, rehandshake, sync_rectifier_switch;
  fbs_sense_s sense = 8'hc0;
  fbs_status_s status;
  logic [6:0] obs;
  int bad_count = 0;
  int cmp_count = 0;
  assign obs = {status, switch_on, line_sense_connect};
  always #4 ref_clk = ~ref_clk;
  fbs_seq #(.RESTART_ON_WINDOW(6000), .RESTART_OFF_INTERVAL(3000),
    .SHORT_CIRCUIT_OFF_INTERVAL(3000), .BROWNOUT_DELAY(400),
    .REQUEST_SILENCE_LIMIT(30000)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .sense(sense), .cycle_request(cycle_request), .switch_on(switch_on),
    .line_sense_connect(line_sense_connect), .status(status));
  fbs_sec_model sec_u (.ref_clk(ref_clk), .nrst(nrst), .switch_on(switch_on),
    .go(go), .cycle_request(cycle_request), .rehandshake(rehandshake),
    .sync_rectifier_switch(sync_rectifier_switch));
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [6:0] e, logic [6:0] s);
    cmp_count++;
    if (e !== s)
    begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_lv(int i, logic v, int lim);
    int k;
    k = 0;
    while (obs[i] !== v && k < lim)
    begin
      cyc(1);
      k++;
    end
    chk("wait level", {6'h00, v}, {6'h00, obs[i]});
    if (obs[i] !== v)
      results();
  endtask
  task automatic req;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask
  task automatic handshake;
    req();
    cyc(HS_GAP_CYC - 3);
    req();
    wait_lv(6, 1'b1, 50);
  endtask
  // one requested conduction; hit selects limit and 110% flags d + 1 cycles after switch_on rises
  task automatic conduct(int d, logic [1:0] hit);
    cyc(600);
    req();
    wait_lv(1, 1'b1, 8);
    repeat (d + 1) @(posedge ref_clk);
    sense.current_limit_level <= hit[0];
    sense.current_limit_110 <= hit[1];
    sense.cycle_done <= ~hit[0];
    @(posedge ref_clk);
    sense[2:0] <= 3'h0;
  endtask
  initial
  begin
    cyc(2);
    chk("reset", 7'h01, obs);
    @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(3000);
    chk("line low", 7'h01, obs);
    sense.line_brown_in <= 1'b1;
    cyc(100);
    chk("listen", 7'h01, obs);
    handshake();
    conduct(10, 2'b00);
    cyc(6400);
    chk("sense cut", 7'h00, obs & 7'h01);
    conduct(10, 2'b00);
    cyc(12000);
    req();
    cyc(12);
    chk("audio", 7'h00, obs & 7'h02);
    cyc(13500);
    conduct(10, 2'b00);
    chk("rehandshake", 7'h00, {6'h00, rehandshake});
    conduct(30, 2'b11);
    conduct(30, 2'b11);
    wait_lv(3, 1'b1, 8);
    wait_lv(3, 1'b0, 3300);
    conduct(0, 2'b01);
    wait_lv(2, 1'b1, 8);
    wait_lv(2, 1'b0, 3900);
    conduct(0, 2'b01);
    wait_lv(4, 1'b1, 8);
    wait_lv(4, 1'b0, 3100);
    cyc(2);
    chk("relisten", 7'h00, obs & 7'h7e);
    handshake();
    conduct(10, 2'b00);
    sense.line_brown_out <= 1'b1;
    sense.line_brown_in <= 1'b0;
    wait_lv(4, 1'b1, 450);
    cyc(3500);
    chk("brown hold", 7'h10, obs & 7'h72);
    sense.line_brown_out <= 1'b0;
    sense.line_brown_in <= 1'b1;
    wait_lv(4, 1'b0, 20);
    cyc(2);
    chk("brown relisten", 7'h00, obs & 7'h7e);
    handshake();
    sense.line_over <= 1'b1;
    wait_lv(4, 1'b1, 8);
    cyc(3100);
    chk("over hold", 7'h10, obs & 7'h72);
    sense.line_over <= 1'b0;
    wait_lv(4, 1'b0, 20);
    sense.cycle_done <= 1'b1;
    wait_lv(5, 1'b1, 6100);
    wait_lv(1, 1'b1, 1300);
    wait_lv(4, 1'b1, 6200);
    chk("rehandshake extra", 7'h01, {6'h00, rehandshake});
    results();
  end
endmodule // fbs_seq_test
bind fbs_seq fbs_seq_props #(.BROWNOUT_DELAY(BROWNOUT_DELAY),
  .RESTART_OFF_INTERVAL(RESTART_OFF_INTERVAL)) props_u (.ref_clk(ref_clk), .nrst(nrst),
  .sense(sense), .cycle_request(cycle_request), .switch_on(switch_on),
  .line_sense_connect(line_sense_connect), .status(status));

//--- src/fbs_pkg.sv
// package: timing constants, states and carriers for the flyback protection sequencer
package fbs_pkg;
  localparam int CLK_MHZ = 125;
  // figures in their printed units
  localparam int SOA_SKIP_US = 25;
  localparam int SOA_BLANK_NS = 500;
  localparam int EDGE_BLANK_NS = 200;
  localparam int SHORT_OFF_US = 30;
  localparam int SENSE_OFF_US = 50;
  localparam int HS_GAP_US = 30;
  localparam int AUDIO_LO_US = 83;
  localparam int AUDIO_HI_US = 200;
  localparam int ON_WINDOW_MS = 82;
  // cycle counts: integer division rounds every fraction down, least and longest times alike
  localparam int SOA_SKIP_CYC = SOA_SKIP_US * CLK_MHZ;
  localparam int SOA_BLANK_CYC = (SOA_BLANK_NS * CLK_MHZ) / 1000;
  localparam int EDGE_BLANK_CYC = (EDGE_BLANK_NS * CLK_MHZ) / 1000;
  localparam int SHORT_OFF_CYC = SHORT_OFF_US * CLK_MHZ;
  localparam int SENSE_OFF_CYC = SENSE_OFF_US * CLK_MHZ;
  localparam int HS_GAP_CYC = HS_GAP_US * CLK_MHZ;
  localparam int HS_TOL_CYC = HS_GAP_CYC / 4;
  localparam int AUDIO_LO_CYC = AUDIO_LO_US * CLK_MHZ;
  localparam int AUDIO_HI_CYC = AUDIO_HI_US * CLK_MHZ;
  localparam int ON_WINDOW_CYC = ON_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int CW = 24;
  localparam logic [CW-1:0] CNT_ZERO = 24'h00_0000;

  typedef enum logic [5:0] {
    FBS_INIT = 6'b00_0001,
    FBS_LISTEN = 6'b00_0010,
    FBS_AUTO = 6'b00_0100,
    FBS_SLAVE = 6'b00_1000,
    FBS_RESTART = 6'b01_0000,
    FBS_SHORT_OFF = 6'b10_0000
  } fbs_state_e;

  // primary-side comparator inputs, sampled each clock
  typedef struct packed {
    logic supply_ready;
    logic limit_latched;
    logic line_brown_in;
    logic line_brown_out;
    logic line_over;
    logic current_limit_level;
    logic current_limit_110;
    logic cycle_done;
  } fbs_sense_s;

  typedef struct packed {
    logic secondary_ctrl;
    logic self_ctrl;
    logic restart_off;
    logic safe_area_guard;
    logic rectifier_short_guard;
  } fbs_status_s;
endpackage

//--- src/fbs_seq.sv
// flyback primary sequencer: start-up, wait and listen, handshake and protection timing
`timescale 1ns/1ps
module fbs_seq #(
  parameter int RESTART_ON_WINDOW = fbs_pkg::ON_WINDOW_CYC,
  parameter int RESTART_OFF_INTERVAL = 2 * fbs_pkg::ON_WINDOW_CYC,
  parameter int SHORT_CIRCUIT_OFF_INTERVAL = 2 * fbs_pkg::ON_WINDOW_CYC,
  parameter int BROWNOUT_DELAY = 4000,
  parameter int MIN_OFF_INTERVAL = 500,
  parameter int REQUEST_SILENCE_LIMIT = 8192,
  parameter int AUTO_PERIOD = 1250
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire fbs_pkg::fbs_sense_s sense,
  input wire logic cycle_request,
  output logic switch_on,
  output logic line_sense_connect,
  output fbs_pkg::fbs_status_s status
);
  import fbs_pkg::*;

  fbs_state_e state_q;
  logic [CW-1:0] tmr_q;
  logic [CW-1:0] off_q;
  logic [CW-1:0] since_req_q;
  logic [CW-1:0] bo_q;
  logic [CW-1:0] on_q;
  logic [CW-1:0] skip_q;
  logic soa_hit_q;
  logic short_arm_q;
  logic heard_q;
  logic switch_q;
  logic sense_q;
  logic power_ok_q;

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = n[CW-1:0];
  endfunction

  // line is within its normal window
  function automatic logic line_ok(input fbs_sense_s s);
    line_ok = s.line_brown_in && !s.line_over;
  endfunction

  logic line_fault;
  logic early_hit;
  logic soa_hit;
  logic start_cycle;
  logic req_valid;
  logic end_on;

  assign early_hit = switch_q && sense.current_limit_level && (on_q < cyc(EDGE_BLANK_CYC));
  assign soa_hit = switch_q && sense.current_limit_110 && (on_q < cyc(SOA_BLANK_CYC));
  assign end_on = switch_q && (sense.cycle_done || sense.current_limit_level);
  assign line_fault = sense.line_over || (bo_q >= cyc(BROWNOUT_DELAY));
  // audible-band and minimum-off filtering of requests
  assign req_valid = cycle_request && (off_q >= cyc(MIN_OFF_INTERVAL)) && (skip_q == CNT_ZERO)
    && !((off_q >= cyc(AUDIO_LO_CYC)) && (off_q <= cyc(AUDIO_HI_CYC)));

  always_comb
  begin
    start_cycle = 1'b0;
    if (!switch_q && skip_q == CNT_ZERO)
    begin
      unique case (state_q)
        FBS_SLAVE: start_cycle = req_valid;
        FBS_AUTO: start_cycle = (off_q >= cyc(AUTO_PERIOD));
        default: start_cycle = 1'b0;
      endcase
    end
  end

  // power-up qualification
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      power_ok_q <= 1'b0;
    else if (sense.supply_ready && sense.limit_latched)
      power_ok_q <= 1'b1;
  end

  // brown-out persistence counter
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      bo_q <= CNT_ZERO;
    else if (!sense.line_brown_out)
      bo_q <= CNT_ZERO;
    else if (bo_q < cyc(BROWNOUT_DELAY))
      bo_q <= bo_q + 1'b1;
  end

  // on-time and off-time counters
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      switch_q <= 1'b0;
      on_q <= CNT_ZERO;
      off_q <= CNT_ZERO;
    end
    else if (switch_q)
    begin
      on_q <= on_q + 1'b1;
      if (end_on || early_hit || state_q == FBS_RESTART || state_q == FBS_SHORT_OFF)
      begin
        switch_q <= 1'b0;
        off_q <= CNT_ZERO;
      end
    end
    else
    begin
      on_q <= CNT_ZERO;
      if (off_q != {CW{1'b1}})
        off_q <= off_q + 1'b1;
      if (start_cycle)
        switch_q <= 1'b1;
    end
  end

  // line sense disconnect on long off-time
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      sense_q <= 1'b1;
    else if (start_cycle)
      sense_q <= 1'b1;
    else if (!switch_q && off_q > cyc(SENSE_OFF_CYC))
      sense_q <= 1'b0;
  end

  // safe-area skip and short-circuit off-time
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      skip_q <= CNT_ZERO;
      soa_hit_q <= 1'b0;
      short_arm_q <= 1'b0;
    end
    else
    begin
      if (skip_q != CNT_ZERO)
        skip_q <= skip_q - 1'b1;
      if (switch_q && end_on)
        soa_hit_q <= soa_hit;
      if (switch_q && end_on && soa_hit && soa_hit_q)
      begin
        skip_q <= cyc(SOA_SKIP_CYC);
        soa_hit_q <= 1'b0;
      end
      if (early_hit && !short_arm_q)
      begin
        skip_q <= cyc(SHORT_OFF_CYC);
        short_arm_q <= 1'b1;
      end
      else if (switch_q && end_on)
        short_arm_q <= 1'b0;
    end
  end

  // request silence and listen-window pair detection
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      since_req_q <= CNT_ZERO;
      heard_q <= 1'b0;
    end
    else if (cycle_request)
    begin
      since_req_q <= CNT_ZERO;
      heard_q <= 1'b1;
    end
    else
    begin
      if (since_req_q != {CW{1'b1}})
        since_req_q <= since_req_q + 1'b1;
      if (state_q != FBS_LISTEN && state_q != FBS_AUTO)
        heard_q <= 1'b0;
    end
  end

  logic pair_seen;
  assign pair_seen = cycle_request && heard_q
    && (since_req_q + cyc(HS_TOL_CYC) >= cyc(HS_GAP_CYC))
    && (since_req_q <= cyc(HS_GAP_CYC + HS_TOL_CYC));

  // control state machine
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= FBS_INIT;
      tmr_q <= CNT_ZERO;
    end
    else
    begin
      tmr_q <= tmr_q + 1'b1;
      unique case (state_q)
        FBS_INIT:
          if (power_ok_q && line_ok(sense))
          begin
            state_q <= FBS_LISTEN;
            tmr_q <= CNT_ZERO;
          end
        FBS_LISTEN:
          if (line_fault)
          begin
            state_q <= FBS_RESTART;
            tmr_q <= CNT_ZERO;
          end
          else if (pair_seen)
            state_q <= FBS_SLAVE;
          else if (tmr_q >= cyc(RESTART_ON_WINDOW))
          begin
            state_q <= FBS_AUTO;
            tmr_q <= CNT_ZERO;
          end
        FBS_AUTO:
          if (line_fault || tmr_q >= cyc(RESTART_ON_WINDOW))
          begin
            state_q <= FBS_RESTART;
            tmr_q <= CNT_ZERO;
          end
          else if (pair_seen)
            state_q <= FBS_SLAVE;
        FBS_SLAVE:
          if (line_fault || since_req_q > cyc(REQUEST_SILENCE_LIMIT))
          begin
            state_q <= FBS_RESTART;
            tmr_q <= CNT_ZERO;
          end
          else if (early_hit && short_arm_q)
          begin
            state_q <= FBS_SHORT_OFF;
            tmr_q <= CNT_ZERO;
          end
        FBS_RESTART:
          if (tmr_q >= cyc(RESTART_OFF_INTERVAL) && line_ok(sense))
          begin
            state_q <= FBS_LISTEN;
            tmr_q <= CNT_ZERO;
          end
        FBS_SHORT_OFF:
          if (tmr_q >= cyc(SHORT_CIRCUIT_OFF_INTERVAL) && line_ok(sense))
          begin
            state_q <= FBS_LISTEN;
            tmr_q <= CNT_ZERO;
          end
        default:
          state_q <= FBS_INIT;
      endcase
      if (state_q == FBS_AUTO && early_hit && short_arm_q)
      begin
        state_q <= FBS_SHORT_OFF;
        tmr_q <= CNT_ZERO;
      end
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      switch_on <= 1'b0;
      line_sense_connect <= 1'b1;
      status <= '0;
    end
    else
    begin
      switch_on <= switch_q;
      line_sense_connect <= sense_q;
      status.secondary_ctrl <= (state_q == FBS_SLAVE);
      status.self_ctrl <= (state_q == FBS_AUTO);
      status.restart_off <= (state_q == FBS_RESTART) || (state_q == FBS_SHORT_OFF);
      status.safe_area_guard <= (skip_q != CNT_ZERO) && !short_arm_q;
      // flags only the 30 us off-time itself, not the armed first cycle after it
      status.rectifier_short_guard <= (skip_q != CNT_ZERO) && short_arm_q;
    end
  end
endmodule // fbs_seq
